// ### eeprom_cmd_pkg.sv
package eeprom_cmd_pkg;

  // ----------------------------------------------------------------
  // opcode layout: upper nibble zero, low three bits select command
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_HI = 4'h0;
  localparam int OP_TOP_BIT = 3;
  localparam logic [2:0] OP_SET_LATCH = 3'h6;
  localparam logic [2:0] OP_CLEAR_LATCH = 3'h4;
  localparam logic [2:0] OP_STATUS_READ = 3'h5;
  localparam logic [2:0] OP_STATUS_WRITE = 3'h1;
  localparam logic [2:0] OP_ARRAY_READ = 3'h3;
  localparam logic [2:0] OP_ARRAY_WRITE = 3'h2;

  // ----------------------------------------------------------------
  // status byte fields and reset values
  // ----------------------------------------------------------------
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int PROT_LO_BIT = 2;
  localparam int PROT_HI_BIT = 3;
  localparam logic [3:0] STATUS_FILL = 4'hF;
  localparam logic [1:0] PROTECT_RESET = 2'h0;
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_QUARTER = 2'h1;
  localparam logic [1:0] PROT_HALF = 2'h2;

  // ----------------------------------------------------------------
  // geometry and timing defaults
  // ----------------------------------------------------------------
  localparam int DEF_ADDR_BITS = 9;
  localparam int DEF_PAGE_BYTES = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLE_TIME_NS = 1000000;
  localparam int WRITE_CYCLES_DEF = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // state and request encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    L_OPCODE = 3'h0,
    L_ADDR = 3'h1,
    L_STAT_OUT = 3'h2,
    L_READ_OUT = 3'h3,
    L_WR_DATA = 3'h4,
    L_SR_DATA = 3'h5,
    L_WAIT = 3'h6
  } link_state_e;

  typedef enum logic [1:0] {
    REQ_SET = 2'h0,
    REQ_CLEAR = 2'h1,
    REQ_SR_WRITE = 2'h2,
    REQ_ARRAY_WRITE = 2'h3
  } req_kind_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_ERASE = 2'h1,
    M_PROGRAM = 2'h2
  } cycle_state_e;

endpackage

// ### serial_eeprom_command_core.sv
`timescale 1ns/1ps

module serial_eeprom_command_core #(
  parameter int ADDR_BITS = eeprom_cmd_pkg::DEF_ADDR_BITS,
  parameter int PAGE_BYTES = eeprom_cmd_pkg::DEF_PAGE_BYTES,
  parameter int WRITE_CYCLES = eeprom_cmd_pkg::WRITE_CYCLES_DEF
) (
  // system clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic selN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoEn,
  // protect pin
  input wire logic protectN
);
  import eeprom_cmd_pkg::*;

  localparam int DEPTH = 1 << ADDR_BITS;
  localparam int PB = $clog2(PAGE_BYTES);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam int ERASE_CYC = WRITE_CYCLES / 2;
  localparam int PROG_CYC = WRITE_CYCLES - ERASE_CYC;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (ADDR_BITS < 7 || ADDR_BITS > 9) begin : gBadAddr
    $error("address width must be 7, 8 or 9");
  end
  if (PAGE_BYTES < 2 || (1 << PB) != PAGE_BYTES || PAGE_BYTES >= DEPTH) begin : gBadPage
    $error("page size must be a power of two below the array size");
  end
  if (WRITE_CYCLES < 2) begin : gBadTime
    $error("write cycle must last at least two clocks");
  end

  // ----------------------------------------------------------------
  // storage shared between domains
  // ----------------------------------------------------------------
  logic [7:0] mem [0:DEPTH-1];
  logic [7:0] pageBuf [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pageMask;
  logic [ADDR_BITS-1:0] reqPage;
  logic [1:0] reqProt;
  req_kind_e reqKind;
  logic reqReady;

  // mclk-side state
  logic busy;
  logic latch;
  logic [1:0] prot;
  cycle_state_e cstate;
  logic [CNT_W-1:0] cnt;
  req_kind_e curKind;

  // link-side state
  link_state_e lstate;
  logic [2:0] bitCnt;
  logic [6:0] shiftIn;
  logic isRead;
  logic opTop;
  logic [ADDR_BITS-1:0] addr;
  logic [3:0] statMeta;
  logic [3:0] statL;
  logic linkRstN;
  logic [7:0] inByte;
  logic [8:0] fullAddr;
  logic byteEnd;
  logic [7:0] outByte;

  // ----------------------------------------------------------------
  // link domain: command shifter and decoder
  // ----------------------------------------------------------------
  // deselect resets the frame state; request words survive for mclk
  assign linkRstN = rst_n & ~selN;
  assign inByte = {shiftIn, sdi};
  assign fullAddr = {opTop, inByte};
  assign byteEnd = (bitCnt == 3'h7);

  // bit counter and input shifter, sampled on rising edge
  always_ff @(posedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      bitCnt <= 3'h0;
      shiftIn <= 7'h00;
    end else begin
      bitCnt <= bitCnt + 3'h1;
      shiftIn <= inByte[6:0];
    end
  end

  // command state machine, stepping at each byte boundary
  always_ff @(posedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      lstate <= L_OPCODE;
      isRead <= 1'b0;
      opTop <= 1'b0;
    end else if (byteEnd) begin
      case (lstate)
        L_OPCODE: begin
          opTop <= inByte[OP_TOP_BIT];
          if (inByte[7:4] != OP_HI) begin
            lstate <= L_WAIT;
          end else begin
            case (inByte[2:0])
              OP_STATUS_READ: lstate <= L_STAT_OUT;
              OP_STATUS_WRITE: lstate <= statL[BUSY_BIT] ? L_WAIT : L_SR_DATA;
              OP_ARRAY_READ: begin
                lstate <= statL[BUSY_BIT] ? L_WAIT : L_ADDR;
                isRead <= 1'b1;
              end
              OP_ARRAY_WRITE: begin
                lstate <= statL[BUSY_BIT] ? L_WAIT : L_ADDR;
                isRead <= 1'b0;
              end
              // set and clear latch, and unknown codes, park here
              default: lstate <= L_WAIT;
            endcase
          end
        end
        L_ADDR: lstate <= isRead ? L_READ_OUT : L_WR_DATA;
        L_SR_DATA: lstate <= L_WAIT;
        default: lstate <= lstate;
      endcase
    end
  end

  // address register: load, read increment with wrap, page-local write wrap
  always_ff @(posedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      addr <= '0;
    end else if (byteEnd) begin
      case (lstate)
        L_ADDR: addr <= fullAddr[ADDR_BITS-1:0];
        L_READ_OUT: addr <= addr + 1'b1;
        L_WR_DATA: addr <= {addr[ADDR_BITS-1:PB], addr[PB-1:0] + PB'(1)};
        default: addr <= addr;
      endcase
    end
  end

  // request words for mclk; kept across deselect so the commit can read them
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      reqReady <= 1'b0;
      reqKind <= REQ_SET;
      reqPage <= '0;
      reqProt <= PROTECT_RESET;
      pageMask <= '0;
    end else begin
      // high only between the last bit of a complete unit and the next edge
      reqReady <= 1'b0;
      if (byteEnd) begin
        case (lstate)
          L_OPCODE: begin
            if (inByte[7:4] == OP_HI && inByte[2:0] == OP_SET_LATCH) begin
              reqReady <= 1'b1;
              reqKind <= REQ_SET;
            end
            if (inByte[7:4] == OP_HI && inByte[2:0] == OP_CLEAR_LATCH) begin
              reqReady <= 1'b1;
              reqKind <= REQ_CLEAR;
            end
          end
          L_ADDR: begin
            if (!isRead) begin
              reqPage <= fullAddr[ADDR_BITS-1:0];
              pageMask <= '0;
            end
          end
          L_SR_DATA: begin
            reqReady <= 1'b1;
            reqKind <= REQ_SR_WRITE;
            reqProt <= inByte[PROT_HI_BIT:PROT_LO_BIT];
          end
          L_WR_DATA: begin
            reqReady <= 1'b1;
            reqKind <= REQ_ARRAY_WRITE;
            pageMask[addr[PB-1:0]] <= 1'b1;
          end
          default: reqReady <= 1'b0;
        endcase
      end
    end
  end

  // page buffer data; a later byte at the same offset overwrites the earlier one
  always_ff @(posedge sclk) begin
    if (byteEnd && lstate == L_WR_DATA) begin
      pageBuf[addr[PB-1:0]] <= inByte;
    end
  end

  // status bits brought over into the link domain
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      statMeta <= 4'h0;
      statL <= 4'h0;
    end else begin
      statMeta <= {prot, latch, busy};
      statL <= statMeta;
    end
  end

  // output byte; array is quiet while reads are allowed, so it is read directly
  always_comb begin
    if (lstate == L_STAT_OUT) begin
      outByte = {STATUS_FILL, statL};
    end else begin
      outByte = mem[addr];
    end
  end

  // serial output changes on the falling edge, released on deselect
  always_ff @(negedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      sdo <= 1'b0;
      sdoEn <= 1'b0;
    end else if (lstate == L_STAT_OUT || lstate == L_READ_OUT) begin
      sdo <= outByte[3'h7 - bitCnt];
      sdoEn <= 1'b1;
    end else begin
      sdo <= 1'b0;
      sdoEn <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mclk domain: synchronisers and commit
  // ----------------------------------------------------------------
  logic selMeta;
  logic selS;
  logic selD;
  logic rdyMeta;
  logic rdyS;
  logic protMeta;
  logic protS;
  logic consumed;
  logic protLowSeen;
  logic selRise;
  logic selFall;
  logic accept;
  logic startCycle;

  // select, ready and protect pins each pass two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selMeta <= 1'b1;
      selS <= 1'b1;
      selD <= 1'b1;
      rdyMeta <= 1'b0;
      rdyS <= 1'b0;
      protMeta <= 1'b0;
      protS <= 1'b0;
    end else begin
      selMeta <= selN;
      selS <= selMeta;
      selD <= selS;
      rdyMeta <= reqReady;
      rdyS <= rdyMeta;
      protMeta <= protectN;
      protS <= protMeta;
    end
  end

  assign selRise = selS & ~selD;
  assign selFall = ~selS & selD;
  // a frame with no clocks leaves ready high; consumed stops a repeat commit
  assign accept = selRise & rdyS & ~consumed;

  // functions of the protected region: quarter, half or whole array
  function automatic logic inProtected(input logic [ADDR_BITS-1:0] a, input logic [1:0] p);
    case (p)
      PROT_NONE: inProtected = 1'b0;
      PROT_QUARTER: inProtected = &a[ADDR_BITS-1:ADDR_BITS-2];
      PROT_HALF: inProtected = a[ADDR_BITS-1];
      default: inProtected = 1'b1;
    endcase
  endfunction

  assign startCycle = accept && latch && !busy && !protLowSeen &&
                      (reqKind == REQ_SR_WRITE ||
                       (reqKind == REQ_ARRAY_WRITE && !inProtected(reqPage, prot)));

  // one commit per completed request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      consumed <= 1'b0;
    end else if (accept) begin
      consumed <= 1'b1;
    end else if (!rdyS) begin
      consumed <= 1'b0;
    end
  end

  // remembers a low protect pin at any time while selected
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      protLowSeen <= 1'b0;
    end else if (selFall) begin
      protLowSeen <= ~protS;
    end else if (!selS && !protS) begin
      protLowSeen <= 1'b1;
    end
  end

  // write latch: pin low wins, then set, then clear and completion
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= 1'b0;
    end else if (!protS) begin
      latch <= 1'b0;
    end else if (accept && reqKind == REQ_SET) begin
      latch <= 1'b1;
    end else if (accept && reqKind == REQ_CLEAR) begin
      latch <= 1'b0;
    end else if (cstate == M_PROGRAM && cnt == '0) begin
      latch <= 1'b0;
    end
  end

  // self-timed cycle: erase half, then program half
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cstate <= M_IDLE;
      cnt <= '0;
      busy <= 1'b0;
      curKind <= REQ_SET;
    end else begin
      case (cstate)
        M_IDLE: begin
          if (startCycle) begin
            cstate <= M_ERASE;
            cnt <= CNT_W'(ERASE_CYC - 1);
            busy <= 1'b1;
            curKind <= reqKind;
          end
        end
        M_ERASE: begin
          if (cnt == '0) begin
            cstate <= M_PROGRAM;
            cnt <= CNT_W'(PROG_CYC - 1);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        M_PROGRAM: begin
          if (cnt == '0) begin
            cstate <= M_IDLE;
            busy <= 1'b0;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          cstate <= M_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // protect bits change only at the end of a status write cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prot <= PROTECT_RESET;
    end else if (cstate == M_PROGRAM && cnt == '0 && curKind == REQ_SR_WRITE) begin
      prot <= reqProt;
    end
  end

  // array update: erased bytes read zero, then take the buffered data
  always_ff @(posedge mclk) begin
    if (curKind == REQ_ARRAY_WRITE && cnt == '0 &&
        (cstate == M_ERASE || cstate == M_PROGRAM)) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pageMask[i]) begin
          mem[{reqPage[ADDR_BITS-1:PB], PB'(i)}] <=
            (cstate == M_ERASE) ? 8'h00 : pageBuf[i];
        end
      end
    end
  end

endmodule

// ### serial_eeprom_command_core_monitor.sv
`timescale 1ns/1ps

// ----------------------------------------
// link-side watcher for the command core
// ----------------------------------------
module serial_eeprom_command_core_monitor (
  // system clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic selN,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdoEn,
  // protect pin
  input wire logic protectN
);
  import eeprom_cmd_pkg::*;

  logic [7:0] inShift;
  logic [4:0] inCount;
  logic [2:0] outCount;
  logic isStat;
  logic isArr;
  logic [7:0] nextOp;

  assign nextOp = {inShift[6:0], sdi};

  // input bit count and opcode decode; deselect restarts the frame like the device does
  always_ff @(posedge sclk or posedge selN or negedge rst_n) begin
    if (selN || !rst_n) begin
      inShift <= 8'h00;
      inCount <= 5'h00;
      isStat <= 1'b0;
      isArr <= 1'b0;
    end else begin
      inShift <= nextOp;
      if (inCount != 5'h10) begin
        inCount <= inCount + 5'h01;
      end
      if (inCount == 5'h07) begin
        isStat <= nextOp[7:4] == OP_HI && nextOp[2:0] == OP_STATUS_READ;
        isArr <= nextOp[7:4] == OP_HI && nextOp[2:0] == OP_ARRAY_READ;
      end
    end
  end

  // bit position of the output byte, counted on falling edges once the opcode is in
  always_ff @(negedge sclk or posedge selN or negedge rst_n) begin
    if (selN || !rst_n) begin
      outCount <= 3'h0;
    end else if (inCount >= 5'h08) begin
      outCount <= outCount + 3'h1;
    end
  end

  a_status_fill: assert property (@(posedge sclk) disable iff (!rst_n || selN)
    isStat && outCount inside {3'h1, 3'h2, 3'h3, 3'h4} |-> sdoEn && sdo)
    else $error("status fill bit not driven as one");
  a_nonread_quiet: assert property (@(posedge sclk) disable iff (!rst_n || selN)
    !isStat && !isArr |-> !sdoEn)
    else $error("output enabled on a non-read command");
  a_array_lead: assert property (@(posedge sclk) disable iff (!rst_n || selN)
    isArr && inCount < 5'h10 |-> !sdoEn)
    else $error("array data driven before address complete");
  a_deselect_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    selN |-> !sdoEn)
    else $error("output enabled while deselected");
  a_idle_low: assert property (@(posedge mclk) disable iff (!rst_n)
    !sdoEn |-> !sdo)
    else $error("data out not low while undriven");
  a_falling_launch: assert property (@(posedge mclk) disable iff (!rst_n)
    $changed(sdo) && $past(sdoEn) && sdoEn |-> !sclk)
    else $error("data out changed away from falling clock");
  a_enable_start: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(sdoEn) |-> !selN && !sclk)
    else $error("output enable rose outside a selected low clock");
  a_enable_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(sdoEn) |-> selN)
    else $error("output enable dropped while still selected");
endmodule

bind serial_eeprom_command_core serial_eeprom_command_core_monitor u_mon (
  .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .selN(selN), .sdi(sdi), .sdo(sdo),
  .sdoEn(sdoEn), .protectN(protectN));

// ### spi_host_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// host controller on the serial link
// ----------------------------------------
module spi_host_model (
  // serial link
  output logic sclk,
  output logic selN,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoEn
);
  logic [7:0] rx [0:3];

  initial begin
    sclk = 1'b0;
    selN = 1'b1;
    sdi = 1'b1;
  end

  // one frame: nTx bytes msb first, nRx bytes read back, then stray clocks;
  // the clock stands at its idle level between frames; an undriven answer bit reads x
  task automatic frame(input logic [63:0] txd, input int nTx, input int nRx,
                       input logic cpol, input int extra);
    int total;
    int idx;
    total = 8 * (nTx + nRx) + extra;
    sclk = cpol;
    #3;
    selN = 1'b0;
    for (int k = 0; k < total; k++) begin
      #40;
      sclk = 1'b0;
      sdi = (k < 8 * nTx) ? txd[8 * nTx - 1 - k] : ~sdi;
      #80;
      sclk = 1'b1;
      if (k >= 8 * nTx && k < 8 * (nTx + nRx)) begin
        idx = (k - 8 * nTx) / 8;
        rx[idx] = {rx[idx][6:0], sdoEn ? sdo : 1'bx};
      end
      #40;
    end
    // deselect after the last sampling edge and before any further rising edge
    if (!cpol) begin
      #40 sclk = 1'b0;
    end
    #40 selN = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule

// ### serial_eeprom_command_core_tb.sv
`timescale 1ns/1ps

module serial_eeprom_command_core_tb;
  import eeprom_cmd_pkg::*;

  // long enough that a two-byte status read fits inside one write cycle
  localparam int CYC = 800;

  logic mclk = 1'b0;
  logic rst_n = 1'b1;
  logic protectN = 1'b1;
  logic sclk, selN, sdi, sdo, sdoEn;
  int bad_count = 0;
  int n_tests = 0;

  always #5 mclk = ~mclk;

  serial_eeprom_command_core #(.ADDR_BITS(9), .PAGE_BYTES(16), .WRITE_CYCLES(CYC)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .selN(selN), .sdi(sdi), .sdo(sdo),
    .sdoEn(sdoEn), .protectN(protectN));
  spi_host_model u_host (.sclk(sclk), .selN(selN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn));

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // link helpers
  // ----------------------------------------
  task automatic xfer(input logic [63:0] txd, input int nTx, input int nRx, input int extra);
    @(negedge mclk);
    u_host.frame(txd, nTx, nRx, 1'b0, extra);
  endtask

  // two status bytes in one frame, both must match
  task automatic stat_is(input logic [7:0] exp);
    xfer(64'h05, 1, 2, 0);
    check(u_host.rx[0], exp);
    check(u_host.rx[1], exp);
  endtask

  task automatic rd(input logic [15:0] cmd, input logic [7:0] e0, input logic [7:0] e1);
    xfer({48'h0, cmd}, 2, 2, 0);
    check(u_host.rx[0], e0);
    check(u_host.rx[1], e1);
  endtask

  task automatic wr(input logic [63:0] txd, input int nTx, input int extra);
    xfer(64'h06, 1, 0, 0);
    xfer(txd, nTx, 0, extra);
  endtask

  // polls busy a bounded number of times; a stuck cycle ends the run
  task automatic wait_idle();
    for (int i = 0; i < 10; i++) begin
      xfer(64'h05, 1, 1, 0);
      if (u_host.rx[0][BUSY_BIT] === 1'b0) begin
        return;
      end
    end
    bad_count++;
    $display("[FAIL] t=%0t busy stuck got=%h exp=%h", $time, u_host.rx[0], 8'hF0);
    end_of_test();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_latch();
    stat_is(8'hF0);
    xfer(64'h0E, 1, 0, 0);
    stat_is(8'hF2);
    @(negedge mclk);
    u_host.frame(64'h05, 1, 1, 1'b1, 0);
    check(u_host.rx[0], 8'hF2);
    xfer(64'h0C, 1, 0, 0);
    stat_is(8'hF0);
    xfer(64'hFF05, 2, 1, 0);
    check(u_host.rx[0], 8'hXX);
  endtask

  task automatic t_array();
    wr(64'h0210A53C, 4, 0);
    stat_is(8'hF3);
    xfer(64'h0310, 2, 1, 0);
    check(u_host.rx[0], 8'hXX);
    wait_idle();
    stat_is(8'hF0);
    rd(16'h0310, 8'hA5, 8'h3C);
    wr(64'h021E112233, 5, 0);
    wait_idle();
    rd(16'h031E, 8'h11, 8'h22);
    rd(16'h0310, 8'h33, 8'h3C);
    wr(64'h0AFF77, 3, 0);
    wait_idle();
    wr(64'h020088, 3, 0);
    wait_idle();
    rd(16'h0BFF, 8'h77, 8'h88);
  endtask

  task automatic t_refuse();
    xfer(64'h021099, 3, 0, 0);
    stat_is(8'hF0);
    xfer(64'h010C, 2, 0, 0);
    stat_is(8'hF0);
    wr(64'h021099, 3, 3);
    stat_is(8'hF2);
    rd(16'h0310, 8'h33, 8'h3C);
    xfer(64'h04, 1, 0, 0);
  endtask

  task automatic t_protect();
    wr(64'h0105, 2, 0);
    stat_is(8'hF3);
    wait_idle();
    stat_is(8'hF4);
    wr(64'h0AFF55, 3, 0);
    stat_is(8'hF6);
    rd(16'h0BFF, 8'h77, 8'h88);
    wr(64'h0A7E6667, 4, 0);
    wait_idle();
    rd(16'h0B7E, 8'h66, 8'h67);
    // latch is set first so that the pin, not a spent latch, is what clears it
    xfer(64'h06, 1, 0, 0);
    stat_is(8'hF6);
    // pin low drops the latch and holds off any status write
    @(negedge mclk);
    protectN = 1'b0;
    stat_is(8'hF4);
    wr(64'h0100, 2, 0);
    @(negedge mclk);
    protectN = 1'b1;
    stat_is(8'hF4);
    // one stray clock after the data byte: no cycle, latch kept
    wr(64'h0100, 2, 1);
    stat_is(8'hF6);
    wr(64'h0100, 2, 0);
    wait_idle();
    stat_is(8'hF0);
    // upper-half protection blocks a write that quarter protection let through
    wr(64'h0108, 2, 0);
    wait_idle();
    stat_is(8'hF8);
    wr(64'h0A7EAA, 3, 0);
    stat_is(8'hFA);
    rd(16'h0B7E, 8'h66, 8'h67);
  endtask

  // mid-run reset: latch and protect bits return to reset values, array kept
  task automatic t_reset();
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (5) @(negedge mclk);
    stat_is(8'hF0);
    rd(16'h0B7E, 8'h66, 8'h67);
  endtask

  initial begin
    #2 rst_n = 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (5) @(negedge mclk);
    t_latch();
    t_array();
    t_refuse();
    t_protect();
    t_reset();
    end_of_test();
  end

  // hang guard
  initial begin
    #1000000;
    bad_count++;
    $display("[FAIL] t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
    end_of_test();
  end
endmodule
